// *** design/rsc_top.v ***
// Serial status and configuration block of the receiver
`include "rsc_consts.vh"

module rsc_top #(
    parameter MS_CYCLES = `RSC_T_MS_NS / `RSC_CLK_PERIOD_NS,
    parameter CAL_PERIOD_MS = `RSC_T_CAL_S * 1000
) (
    input wire clk_sys,
    input wire rst_n,
    input wire spi_sck,
    input wire spi_sdi,
    input wire chip_select_n,
    output reg spi_sdo,
    output reg spi_sdo_oe,
    input wire ext_wake_pin_n,
    output reg host_irq_n,
    output reg active_mode,
    input wire sleep_req,
    input wire [4:0] fifo_bit_count,
    input wire [3:0] fifo_fill_limit,
    input wire fifo_overflow_evt,
    input wire fifo_empty_flag,
    input wire supply_below_thresh,
    input wire signal_above_threshold,
    input wire good_quality_flag,
    input wire clock_recovery_locked,
    input wire afa_done,
    input wire [5:0] afa_offset,
    input wire [15:0] wake_period_ms,
    output reg [1:0] band_select,
    output reg low_supply_detect_on,
    output reg wake_timer_on,
    output reg xtal_osc_on,
    output reg [3:0] crystal_load_sel,
    output reg [2:0] baseband_bw_sel,
    output reg clock_out_disable,
    output reg osc_run,
    output reg calib_active
);
    wire sck_s;
    wire sdi_s;
    wire cs_n_s;
    wire wake_n_s;
    wire sck_rise;
    wire sck_fall;
    wire cs_fall;
    wire cs_rise;
    wire fill_now;
    wire [15:0] status_word;
    wire timer_exp;
    wire cal_exp;
    wire wake_any;
    reg sck_prev_q;
    reg cs_prev_q;
    reg [4:0] bit_cnt_q;
    reg is_read_q;
    reg [15:0] rx_q;
    reg [15:0] tx_q;
    reg rd_done_q;
    reg fill_q;
    reg ovr_q;
    reg wk_q;
    reg lowsup_q;
    reg tgl_q;
    reg stable_q;
    reg [5:0] off_q;
    reg [17:0] ms_cnt_q;
    reg tick_ms_q;
    reg [7:0] cal_cnt_q;

    // Pins come from the host's domain; chip select idles high
    rsc_sync #(.W(4), .INIT(4'h9)) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({chip_select_n, spi_sck, spi_sdi, ext_wake_pin_n}),
        .sync_out({cs_n_s, sck_s, sdi_s, wake_n_s})
    );

    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign cs_fall = ~cs_n_s & cs_prev_q;
    assign cs_rise = cs_n_s & ~cs_prev_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
        end
    end

    assign status_word = {fill_q, ovr_q, wk_q, lowsup_q, fifo_empty_flag,
                          signal_above_threshold, good_quality_flag,
                          clock_recovery_locked, tgl_q, stable_q, off_q};

    // Serial receive, status shift-out and command decode
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 5'h00;
            is_read_q <= 1'b0;
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
            rd_done_q <= 1'b0;
            band_select <= 2'h1;
            low_supply_detect_on <= 1'b0;
            wake_timer_on <= 1'b0;
            xtal_osc_on <= 1'b1;
            crystal_load_sel <= 4'h3;
            baseband_bw_sel <= 3'h5;
            clock_out_disable <= 1'b0;
        end else begin
            rd_done_q <= 1'b0;
            if (cs_fall) begin
                bit_cnt_q <= 5'h00;
                is_read_q <= 1'b0;
                tx_q <= {status_word[14:0], 1'b0};
                spi_sdo <= status_word[15];
                spi_sdo_oe <= 1'b1;
            end else if (!cs_n_s) begin
                if (sck_rise) begin
                    rx_q <= {rx_q[14:0], sdi_s};
                    if (bit_cnt_q == 5'h00) begin
                        is_read_q <= ~sdi_s;
                        spi_sdo_oe <= ~sdi_s;
                    end
                    // Saturate past sixteen so an over-long frame is discarded
                    if (bit_cnt_q <= `RSC_WORD_BITS) begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                if (sck_fall && is_read_q) begin
                    spi_sdo <= tx_q[15];
                    tx_q <= {tx_q[14:0], 1'b0};
                end
            end
            if (cs_rise) begin
                spi_sdo_oe <= 1'b0;
                spi_sdo <= 1'b0;
                if (bit_cnt_q == `RSC_WORD_BITS) begin
                    if (is_read_q) begin
                        rd_done_q <= 1'b1;
                    end else if (rx_q[15:13] == `RSC_CFG_CMD) begin
                        band_select <= rx_q[`RSC_CF_BAND_HI:`RSC_CF_BAND_LO];
                        low_supply_detect_on <= rx_q[`RSC_CF_LSD];
                        wake_timer_on <= rx_q[`RSC_CF_WKT];
                        xtal_osc_on <= rx_q[`RSC_CF_OSC];
                        crystal_load_sel <= rx_q[`RSC_CF_CAP_HI:`RSC_CF_CAP_LO];
                        baseband_bw_sel <= rx_q[`RSC_CF_BB_HI:`RSC_CF_BB_LO];
                        clock_out_disable <= rx_q[`RSC_CF_CLKDIS];
                    end
                end
            end
        end
    end

    assign fill_now = fifo_bit_count >= {1'b0, fifo_fill_limit};

    // Status flags; an event in the clearing cycle keeps its flag set
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill_q <= 1'b0;
            ovr_q <= 1'b0;
            wk_q <= 1'b0;
            lowsup_q <= 1'b0;
            tgl_q <= 1'b0;
            stable_q <= 1'b0;
            off_q <= 6'h00;
        end else begin
            fill_q <= fill_now;
            lowsup_q <= low_supply_detect_on & supply_below_thresh;
            if (fifo_overflow_evt) begin
                ovr_q <= 1'b1;
            end else if (rd_done_q) begin
                ovr_q <= 1'b0;
            end
            if (timer_exp) begin
                wk_q <= 1'b1;
            end else if (rd_done_q) begin
                wk_q <= 1'b0;
            end
            if (afa_done) begin
                tgl_q <= ~tgl_q;
                stable_q <= (afa_offset == off_q);
                off_q <= afa_offset;
            end
        end
    end

    // Millisecond enable shared by the wake and calibration timers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_q <= 18'h00000;
            tick_ms_q <= 1'b0;
        end else if (ms_cnt_q == MS_CYCLES[17:0] - 18'h00001) begin
            ms_cnt_q <= 18'h00000;
            tick_ms_q <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 18'h00001;
            tick_ms_q <= 1'b0;
        end
    end

    rsc_ms_timer u_wake_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_ms(tick_ms_q),
        .enable(wake_timer_on),
        .period_ms(wake_period_ms),
        .expire(timer_exp)
    );

    rsc_ms_timer u_cal_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_ms(tick_ms_q),
        .enable(1'b1),
        .period_ms(CAL_PERIOD_MS[15:0]),
        .expire(cal_exp)
    );

    // Calibration runs once after reset, then on every period, asleep or not
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cal_cnt_q <= `RSC_CAL_HOLD_CYC;
            calib_active <= 1'b0;
            osc_run <= 1'b0;
        end else begin
            if (cal_exp) begin
                cal_cnt_q <= `RSC_CAL_HOLD_CYC;
            end else if (cal_cnt_q != 8'h00) begin
                cal_cnt_q <= cal_cnt_q - 8'h01;
            end
            calib_active <= (cal_cnt_q != 8'h00);
            // Oscillator forced on briefly for calibration if software left it off
            osc_run <= xtal_osc_on | (cal_cnt_q != 8'h00);
        end
    end

    assign wake_any = ~wake_n_s | lowsup_q | fill_q | wk_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_irq_n <= 1'b1;
            active_mode <= 1'b1;
        end else begin
            host_irq_n <= ~(wake_any | timer_exp);
            if (wake_any || !cs_n_s) begin
                active_mode <= 1'b1;
            end else if (sleep_req) begin
                active_mode <= 1'b0;
            end
        end
    end
endmodule // rsc_top

// *** design/rsc_consts.vh ***
// Constants of the receiver serial status and configuration block
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
`define RSC_WORD_BITS 5'h10
`define RSC_CFG_CMD 3'h4
`define RSC_CFG_RESET 16'h893a
`define RSC_CLK_PERIOD_NS 5
`define RSC_T_MS_NS 1000000
`define RSC_T_CAL_S 30
`define RSC_CAL_HOLD_CYC 8'h40
`define RSC_ST_FILL 15
`define RSC_ST_OVR 14
`define RSC_ST_WAKE 13
`define RSC_CF_BAND_HI 12
`define RSC_CF_BAND_LO 11
`define RSC_CF_LSD 10
`define RSC_CF_WKT 9
`define RSC_CF_OSC 8
`define RSC_CF_CAP_HI 7
`define RSC_CF_CAP_LO 4
`define RSC_CF_BB_HI 3
`define RSC_CF_BB_LO 1
`define RSC_CF_CLKDIS 0
`endif

// *** design/rsc_sync.v ***
// Two-flop synchroniser for a group of asynchronous levels
module rsc_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // rsc_sync

// *** design/rsc_ms_timer.v ***
// Millisecond interval timer that pulses on each period expiry
module rsc_ms_timer (
    input wire clk_sys,
    input wire rst_n,
    input wire tick_ms,
    input wire enable,
    input wire [15:0] period_ms,
    output reg expire
);
    reg [15:0] count_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (!enable) begin
                count_q <= 16'h0000;
            end else if (tick_ms) begin
                // A zero period is treated as one millisecond
                if (count_q + 16'h0001 >= period_ms) begin
                    count_q <= 16'h0000;
                    expire <= 1'b1;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end
        end
    end
endmodule // rsc_ms_timer

// *** testbench/rsc_top_monitor.sv ***
// Assertion checker bound to the serial status and configuration block
module rsc_top_monitor #(parameter MS_CYCLES = 10, parameter CAL_PERIOD_MS = 20) (
    input wire clk_sys,
    input wire rst_n,
    input wire chip_select_n,
    input wire spi_sdo_oe,
    input wire ext_wake_pin_n,
    input wire host_irq_n,
    input wire active_mode,
    input wire [4:0] fifo_bit_count,
    input wire [3:0] fifo_fill_limit,
    input wire supply_below_thresh,
    input wire low_supply_detect_on,
    input wire [1:0] band_select,
    input wire [3:0] crystal_load_sel,
    input wire [2:0] baseband_bw_sel,
    input wire xtal_osc_on,
    input wire osc_run,
    input wire calib_active
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [7:0] cal_cnt_q;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) cal_cnt_q <= 8'h00;
        else cal_cnt_q <= calib_active ? cal_cnt_q + 8'h01 : 8'h00;
    end
    property p_irq_ext; !ext_wake_pin_n [*3] |-> ##[0:3] !host_irq_n; endproperty
    a_irq_ext: assert property (p_irq_ext) else $error("no irq on wake pin");
    property p_irq_fill; (fifo_bit_count >= {1'b0, fifo_fill_limit}) [*3] |-> ##[0:1] !host_irq_n; endproperty
    a_irq_fill: assert property (p_irq_fill) else $error("no irq on fill");
    property p_irq_lsd; (low_supply_detect_on && supply_below_thresh) [*3] |-> ##[0:1] !host_irq_n; endproperty
    a_irq_lsd: assert property (p_irq_lsd) else $error("no irq on low supply");
    property p_act_cs; !chip_select_n [*4] |-> ##[0:2] active_mode; endproperty
    a_act_cs: assert property (p_act_cs) else $error("select did not wake");
    property p_oe_idle; chip_select_n [*5] |-> !spi_sdo_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside frame");
    property p_cfg_hold; !$stable({band_select, crystal_load_sel, baseband_bw_sel, xtal_osc_on}) |-> chip_select_n; endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed inside frame");
    property p_cal_len; cal_cnt_q <= 8'h40; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too long");
    property p_osc_run; calib_active [*2] |-> osc_run; endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator off in calibration");
endmodule // rsc_top_monitor

bind rsc_top rsc_top_monitor #(.MS_CYCLES(MS_CYCLES), .CAL_PERIOD_MS(CAL_PERIOD_MS)) rsc_top_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(chip_select_n), .spi_sdo_oe(spi_sdo_oe),
    .ext_wake_pin_n(ext_wake_pin_n), .host_irq_n(host_irq_n), .active_mode(active_mode),
    .fifo_bit_count(fifo_bit_count), .fifo_fill_limit(fifo_fill_limit), .supply_below_thresh(supply_below_thresh),
    .low_supply_detect_on(low_supply_detect_on), .band_select(band_select), .crystal_load_sel(crystal_load_sel),
    .baseband_bw_sel(baseband_bw_sel), .xtal_osc_on(xtal_osc_on), .osc_run(osc_run), .calib_active(calib_active));

// *** testbench/rsc_host_model.sv ***
// Host serial master model sending word frames
module rsc_host_model (
    output logic spi_sck,
    output logic spi_sdi,
    output logic chip_select_n,
    input wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_sck = 1'b0;
        spi_sdi = 1'b1;
        chip_select_n = 1'b1;
    end
    // Sends n bits of w; short frames only where a test asks for one
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        chip_select_n = 1'b0;
        #62.5;
        for (int i = 0; i < n; i++) begin
            spi_sdi = w[15 - i];
            #62.5 spi_sck = 1'b1;
            rd = {rd[14:0], spi_sdo};
            #62.5 spi_sck = 1'b0;
        end
        #62.5 chip_select_n = 1'b1;
        spi_sdi = ~spi_sdi;
        #62.5;
    endtask
endmodule // rsc_host_model

// *** testbench/tb_top.sv ***
// Self-checking testbench of the serial status and configuration block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, ext_wake_pin_n = 1'b1, sleep_req = 1'b0, fifo_overflow_evt = 1'b0;
    logic fifo_empty_flag = 1'b0, supply_below_thresh = 1'b0, signal_above_threshold = 1'b0;
    logic good_quality_flag = 1'b0, clock_recovery_locked = 1'b0, afa_done = 1'b0;
    logic [4:0] fifo_bit_count = 5'h00;
    logic [3:0] fifo_fill_limit = 4'h8;
    logic [5:0] afa_offset = 6'h00;
    logic [15:0] wake_period_ms = 16'h0001;
    logic [15:0] rd;
    logic spi_sck, spi_sdi, chip_select_n, spi_sdo, spi_sdo_oe, host_irq_n, active_mode, low_supply_detect_on;
    logic wake_timer_on, xtal_osc_on, clock_out_disable, osc_run, calib_active;
    logic [1:0] band_select;
    logic [3:0] crystal_load_sel;
    logic [2:0] baseband_bw_sel;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    wire [15:0] cfg = {3'h0, band_select, low_supply_detect_on, wake_timer_on, xtal_osc_on,
                       crystal_load_sel, baseband_bw_sel, clock_out_disable};
    rsc_top #(.MS_CYCLES(10), .CAL_PERIOD_MS(20)) rsc_top_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi), .chip_select_n(chip_select_n),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ext_wake_pin_n(ext_wake_pin_n), .host_irq_n(host_irq_n),
        .active_mode(active_mode), .sleep_req(sleep_req), .fifo_bit_count(fifo_bit_count),
        .fifo_fill_limit(fifo_fill_limit), .fifo_overflow_evt(fifo_overflow_evt), .fifo_empty_flag(fifo_empty_flag),
        .supply_below_thresh(supply_below_thresh), .signal_above_threshold(signal_above_threshold),
        .good_quality_flag(good_quality_flag), .clock_recovery_locked(clock_recovery_locked),
        .afa_done(afa_done), .afa_offset(afa_offset), .wake_period_ms(wake_period_ms),
        .band_select(band_select), .low_supply_detect_on(low_supply_detect_on), .wake_timer_on(wake_timer_on),
        .xtal_osc_on(xtal_osc_on), .crystal_load_sel(crystal_load_sel), .baseband_bw_sel(baseband_bw_sel),
        .clock_out_disable(clock_out_disable), .osc_run(osc_run), .calib_active(calib_active));
    rsc_host_model rsc_host_model_i (.spi_sck(spi_sck), .spi_sdi(spi_sdi), .chip_select_n(chip_select_n),
                                     .spi_sdo(spi_sdo));
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic xf(input logic [15:0] w, input int n);
        rsc_host_model_i.xfer(w, n, rd);
        step(1);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset;
        step(2);
        cmp(cfg, 16'h093a, "reset cfg");
        cmp({12'h0, calib_active, osc_run, host_irq_n, active_mode}, 16'h000f, "reset flags");
        $display("t_reset done");
    endtask
    task automatic t_cfg;
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            w = {3'h4, i[1:0], i[0], i[1], i[2], i[0], i[2:0], i[2:0], i[0]};
            xf(w, 16);
            // Band changes here skip synthesizer recalibration, which the host owes
            cmp(cfg, {3'h0, w[12:0]}, "cfg write");
        end
        xf(16'h8000, 15);
        cmp(cfg, 16'h1fff, "short frame");
        xf(16'ha000, 16);
        cmp(cfg, 16'h1fff, "other code");
        $display("t_cfg done");
    endtask
    task automatic t_status;
        xf(16'h8400, 16);
        // Clear the wake flag left by the timer running during the configuration test
        xf(16'h0000, 16);
        fifo_bit_count = 5'h08;
        fifo_empty_flag = 1'b1;
        supply_below_thresh = 1'b1;
        signal_above_threshold = 1'b1;
        clock_recovery_locked = 1'b1;
        fifo_overflow_evt = 1'b1;
        afa_offset = 6'h25;
        for (int i = 0; i < 3; i++) begin
            afa_done = 1'b1;
            step(1);
            fifo_overflow_evt = 1'b0;
            afa_done = 1'b0;
            step(1);
        end
        step(2);
        cmp({15'h0, host_irq_n}, 16'h0000, "fill irq");
        xf(16'h0000, 16);
        cmp(rd, 16'hdde5, "status");
        fifo_bit_count = 5'h07;
        fifo_empty_flag = 1'b0;
        supply_below_thresh = 1'b0;
        afa_offset = 6'h0a;
        afa_done = 1'b1;
        step(1);
        afa_done = 1'b0;
        step(2);
        xf(16'h0000, 16);
        cmp(rd, 16'h050a, "status after read");
        $display("t_status done");
    endtask
    task automatic t_wake;
        xf(16'h8200, 16);
        step(40);
        cmp({15'h0, host_irq_n}, 16'h0000, "timer irq");
        xf(16'h8000, 16);
        xf(16'h0000, 16);
        cmp(rd, 16'h250a, "timer flag");
        xf(16'h0000, 16);
        cmp(rd, 16'h050a, "timer flag gone");
        cmp({15'h0, host_irq_n}, 16'h0001, "irq idle");
        sleep_req = 1'b1;
        step(3);
        sleep_req = 1'b0;
        cmp({15'h0, active_mode}, 16'h0000, "sleep");
        ext_wake_pin_n = 1'b0;
        step(6);
        cmp({14'h0, active_mode, host_irq_n}, 16'h0002, "pin wake");
        ext_wake_pin_n = 1'b1;
        for (int k = 0; k < 400 && calib_active !== 1'b1; k++) step(1);
        cmp({14'h0, osc_run, xtal_osc_on}, 16'h0002, "calibration");
        $display("t_wake done");
    endtask
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            give_verdict;
        end
    end
    initial begin
        step(20);
        rst_n = 1'b1;
        t_reset;
        t_cfg;
        t_status;
        t_wake;
        give_verdict;
    end
endmodule // tb_top
